/* File: logic/irq_prio_map.svh */
// register offsets, field positions, reset values for the priority registers
`ifndef IRQ_PRIO_MAP_SVH
`define IRQ_PRIO_MAP_SVH
`define UART_ERR_PRIO_OFFSET   4'h0
`define PWM_PAIR_PRIO_OFFSET   4'h2
`define SERIAL_ERR_FIELD_LSB   4
`define GEN1_FIELD_LSB         8
`define GEN2_FIELD_LSB         12
`define PRIO_FIELD_RESET       3'h4
`define PRIO_LEVEL_OFF         3'h0
`endif

/* File: logic/irq_prio_pkg.sv */
// types shared by the priority register block
`default_nettype none
package irq_prio_pkg;
  typedef logic [2:0] prio_level_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;
  typedef struct packed {
    prio_level_t serial_err;
    prio_level_t gen1;
    prio_level_t gen2;
  } prio_set_t;
endpackage
`default_nettype wire

/* File: logic/prio_field.sv */
// one 3-bit priority field with reset value and active indication
`include "irq_prio_map.svh"
`default_nettype none
module prio_field
(
  input  wire logic                      clock,
  input  wire logic                      nrst,
  input  wire logic                      we,
  input  wire irq_prio_pkg::prio_level_t wval,
  output var  irq_prio_pkg::prio_level_t level,
  output var  logic                      enabled
);
  import irq_prio_pkg::*;

  prio_level_t level_r;
  always_ff @(posedge clock)
  begin
    if (!nrst)
      level_r <= `PRIO_FIELD_RESET;
    else if (we)
      level_r <= wval;
  end
  assign level   = level_r;
  assign enabled = (level_r != `PRIO_LEVEL_OFF);
endmodule
`default_nettype wire

/* File: logic/irq_prio_regs.sv */
// priority level registers for serial error and two pulse generator interrupts
//
// The address map and the address-and-strobe port were decided locally.
`include "irq_prio_map.svh"
`default_nettype none
// Contract
// - the serial error priority field is writable in bits 6 to 4 of its register.
// - the second generator priority field is writable in bits 14 to 12 of the pair register.
// - the first generator priority field is writable in bits 10 to 8 of the pair register.
// - field value 111 gives level 7, the highest.
// - field value 001 gives level 1, the lowest enabled.
// - field value 000 disables the source so it never requests.
// - all other bits ignore writes and read as zero.
// - every field resets to 100 and is fully readable and writable.
module irq_prio_regs
(
  input  wire logic                    clock,
  input  wire logic                    nrst,
  input  wire logic [3:0]              addr,
  input  wire logic [15:0]             wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  input  wire logic [2:0]              src_flag,
  output var  logic [15:0]             rdata,
  output var  irq_prio_pkg::prio_set_t levels,
  output var  logic [2:0]              src_req
);
  import irq_prio_pkg::*;

  // pick one 3-bit field out of a bus word
  function automatic prio_level_t field_at(input logic [15:0] word, input int unsigned lsb);
    field_at = word[lsb +: 3];
  endfunction

  // true when the bus address targets the given register
  function automatic logic hits(input logic [3:0] a, input logic [3:0] offset);
    hits = (a == offset);
  endfunction

  prio_set_t   lv;
  logic [2:0]  en;
  logic        sel_u;
  logic        sel_p;
  logic        sel_none;
  logic        wr_u;
  logic        wr_p;
  prio_level_t wval_ser;
  prio_level_t wval_g1;
  prio_level_t wval_g2;
  logic [15:0] rd_u;
  logic [15:0] rd_p;
  logic [15:0] rd_nxt;
  logic [15:0] rdata_r;
  prio_set_t   levels_r;
  logic [2:0]  req_nxt;
  logic [2:0]  req_r;

  // address decode; any other address is an unmapped hole
  assign sel_u    = hits(addr, `UART_ERR_PRIO_OFFSET);
  assign sel_p    = hits(addr, `PWM_PAIR_PRIO_OFFSET);
  assign sel_none = !sel_u && !sel_p;

  // one strobe loads both generator fields of the pair word
  assign wr_u     = wr && sel_u;
  assign wr_p     = wr && sel_p;

  assign wval_ser = field_at(wdata, `SERIAL_ERR_FIELD_LSB);
  assign wval_g1  = field_at(wdata, `GEN1_FIELD_LSB);
  assign wval_g2  = field_at(wdata, `GEN2_FIELD_LSB);

  prio_field u_ser
  (
    .clock   (clock),
    .nrst    (nrst),
    .we      (wr_u),
    .wval    (wval_ser),
    .level   (lv.serial_err),
    .enabled (en[0])
  );

  prio_field u_g1
  (
    .clock   (clock),
    .nrst    (nrst),
    .we      (wr_p),
    .wval    (wval_g1),
    .level   (lv.gen1),
    .enabled (en[1])
  );

  prio_field u_g2
  (
    .clock   (clock),
    .nrst    (nrst),
    .we      (wr_p),
    .wval    (wval_g2),
    .level   (lv.gen2),
    .enabled (en[2])
  );

  assign rd_u   = {9'h000, lv.serial_err, 4'h0};
  assign rd_p   = {1'b0, lv.gen2, 1'b0, lv.gen1, 8'h00};
  // zeros outside a read cycle, so stale words never linger on the bus
  assign rd_nxt = !rd ? 16'h0000 : sel_u ? rd_u : sel_p ? rd_p : 16'h0000;

  assign req_nxt = src_flag & en;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      rdata_r  <= 16'h0000;
      levels_r <= {3{`PRIO_FIELD_RESET}};
      req_r    <= 3'h0;
    end
    else
    begin
      rdata_r  <= rd_nxt;
      levels_r <= lv;
      req_r    <= req_nxt;
    end
  end

  assign rdata   = rdata_r;
  assign levels  = levels_r;
  assign src_req = req_r;

  a_reset_value: assert property (@(posedge clock)
    !nrst |=> lv.gen1 == `PRIO_FIELD_RESET && lv.gen2 == `PRIO_FIELD_RESET
    && lv.serial_err == `PRIO_FIELD_RESET)
    else $error("field reset value wrong");

  a_serial_write: assert property (@(posedge clock) disable iff (!nrst)
    wr && sel_u |=> lv.serial_err == $past(wdata[6:4]))
    else $error("serial field not written");

  a_gen2_write: assert property (@(posedge clock) disable iff (!nrst)
    wr && sel_p |=> lv.gen2 == $past(wdata[14:12]))
    else $error("gen2 field not written");

  a_gen1_write: assert property (@(posedge clock) disable iff (!nrst)
    wr && sel_p |=> lv.gen1 == $past(wdata[10:8]))
    else $error("gen1 field not written");

  a_read_zeros: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |=> (rdata & 16'h888f) == 16'h0000)
    else $error("unimplemented bits read nonzero");

  a_uart_zeros: assert property (@(posedge clock) disable iff (!nrst)
    rd && sel_u |=> (rdata & 16'hff8f) == 16'h0000)
    else $error("serial word unused bits nonzero");

  a_idle_zero: assert property (@(posedge clock) disable iff (!nrst)
    !rd |=> rdata == 16'h0000)
    else $error("read data nonzero without read");

  a_unmapped_read: assert property (@(posedge clock) disable iff (!nrst)
    rd && sel_none |=> rdata == 16'h0000)
    else $error("unmapped read nonzero");

  a_unmapped_write: assert property (@(posedge clock) disable iff (!nrst)
    wr && sel_none |=> $stable(lv))
    else $error("unmapped write changed a field");

  a_level_top: assert property (@(posedge clock) disable iff (!nrst)
    lv.gen2 == 3'h7 |=> levels.gen2 == 3'h7)
    else $error("level 7 not passed");

  a_level_low: assert property (@(posedge clock) disable iff (!nrst)
    lv.gen1 == 3'h1 ##1 lv.gen1 == 3'h1 |-> levels.gen1 == 3'h1)
    else $error("level 1 not passed");

  a_enabled_req: assert property (@(posedge clock) disable iff (!nrst)
    src_flag[0] && lv.serial_err != 3'h0 |=> src_req[0])
    else $error("enabled source did not request");

  a_disabled_src: assert property (@(posedge clock) disable iff (!nrst)
    lv.serial_err == 3'h0 |=> !src_req[0])
    else $error("disabled source requested");

  a_gen1_disabled: assert property (@(posedge clock) disable iff (!nrst)
    lv.gen1 == 3'h0 |=> !src_req[1])
    else $error("disabled gen1 source requested");

  a_gen2_disabled: assert property (@(posedge clock) disable iff (!nrst)
    lv.gen2 == 3'h0 |=> !src_req[2])
    else $error("disabled gen2 source requested");

  a_level_direct: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |=> levels == $past(lv))
    else $error("level mapping not direct");

  a_read_back: assert property (@(posedge clock) disable iff (!nrst)
    rd && sel_p |=> rdata[14:12] == levels.gen2)
    else $error("pair readback wrong");

  a_serial_read: assert property (@(posedge clock) disable iff (!nrst)
    rd && sel_u |=> rdata[6:4] == $past(lv.serial_err))
    else $error("serial readback wrong");

  a_field_hold: assert property (@(posedge clock) disable iff (!nrst)
    !wr |=> $stable(lv))
    else $error("field changed without write");

  // main scenarios worth seeing at least once
  c_write_uart: cover property (@(posedge clock) wr && sel_u);
  c_write_pair: cover property (@(posedge clock) wr && sel_p ##1 rd && sel_p);
  c_disable: cover property (@(posedge clock) lv.gen1 == 3'h0 && src_flag[1]);
  c_level_top: cover property (@(posedge clock) lv.gen2 == 3'h7 && rd && sel_p);
  c_unmapped: cover property (@(posedge clock) wr && sel_none);
endmodule
`default_nettype wire

/* File: test/flag_src.sv */
// far-side model: interrupt flags that change every cycle
`default_nettype none
module flag_src
(
  input  wire logic       clock,
  output var  logic [2:0] src_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  initial src_flag = 3'h0;
  // odd step walks all eight flag patterns
  always @(posedge clock)
    src_flag <= src_flag + 3'h3;
endmodule
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench for the priority register block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_prio_pkg::*;
  logic        clock = 0, nrst = 0, wr = 0, rd = 0, rd_d = 0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0, rdata, exq[$];
  logic [2:0]  src_flag, src_req, f_d = 3'h0, s, g1, g2, p;
  logic [31:0] lf = 32'h0db7;
  prio_set_t   levels;
  int          num_errors = 0, num_checks = 0, cyc = 0;
  irq_prio_regs u_irq_prio_regs (.clock, .nrst, .addr, .wdata, .wr, .rd, .src_flag, .rdata, .levels, .src_req);
  flag_src u_flag_src (.clock, .src_flag);
  always #2 clock = ~clock;
  function logic [31:0] nx(input logic [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s exp %h got %h", n, e, g);
      num_errors++;
    end
  endtask
  task report_and_stop();
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one bus cycle; a read notes its expected word for the monitor
  task acc(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    wr    <= w;
    rd    <= r;
    addr  <= a;
    wdata <= d;
    if (w && a == 4'h0) s = d[6:4];
    if (w && a == 4'h2) {g2, g1} = {d[14:12], d[10:8]};
    if (r) exq.push_back(a == 4'h0 ? {9'h0, s, 4'h0} : a == 4'h2 ? {1'h0, g2, 1'h0, g1, 8'h0} : 16'h0);
    @(posedge clock);
  endtask
  // levels lag the fields, so let them settle first
  task chk();
    repeat (3) acc(0, 0, 4'h0, 16'h0);
    #1;
    cmp("levels", {7'h0, s, g1, g2}, levels);
    cmp("src_req", {13'h0, f_d & {g2 != 0, g1 != 0, s != 0}}, {13'h0, src_req});
    @(posedge clock);
  endtask
  always @(posedge clock)
  begin
    rd_d <= rd;
    f_d <= src_flag;
    cyc <= cyc + 1;
    if (rd_d)
      cmp("rdata", exq.pop_front(), rdata);
    else if (nrst)
      cmp("rdata idle", 16'h0000, rdata);
    if (cyc == 2000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  initial
  begin
    {s, g1, g2} = 9'h124;
    repeat (3) @(posedge clock);
    nrst <= 1;
    chk();
    acc(0, 1, 4'h0, 16'h0);
    acc(0, 1, 4'h2, 16'h0);
    for (int v = 0; v < 8; v++)
    begin
      p = v[2:0];
      lf = nx(lf);
      acc(1, 0, 4'h0, {lf[15:7], p, lf[3:0]});
      acc(1, 0, 4'h2, {lf[31], p, lf[27], ~p, lf[23:16]});
      acc(0, 1, 4'h0, 16'h0);
      acc(0, 1, 4'h2, 16'h0);
      chk();
    end
    // a second reset must bring every field back to 100
    nrst <= 0;
    {s, g1, g2} = 9'h124;
    repeat (2) @(posedge clock);
    nrst <= 1;
    acc(0, 1, 4'h2, 16'h0);
    chk();
    acc(1, 0, 4'h5, 16'hffff);
    acc(0, 1, 4'h5, 16'h0);
    acc(0, 1, 4'h0, 16'h0);
    chk();
    report_and_stop();
  end
endmodule
`default_nettype wire
